// ### shared/emb_consts.svh
// Constants for the external memory bus interface
//
// Overview of operation
// - 24-bit address output spans 16M words per static bank
// - SDRAM internal bank select always on address bits 14:13
// - Address bit 10 high with burst read/write requests auto precharge
// - Static banks 8/16/32-bit wide, SDRAM banks 16/32-bit only
// - Two SDRAM chip selects; row and column strobes shared by both
// - Shared write strobe for SDRAM and 16-bit static writes, never 8-bit
// - Eight static chip selects, one asserted as chosen by the req_bank_i bank number
// - Boot bank width straps: 01 byte, 10 halfword, 11 word, 00 reserved
// - Read output enable asserted on every static memory read, not on SDRAM reads
// - Four byte-lane write strobes on writes; SDRAM data masks
// - External master request tristates the external bus pins
// - After request drops, device resumes bus and drives acknowledge low
// - Byte-order strap 0 little endian, 1 big endian lane ordering
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define EMB_ADDR_W        24
`define EMB_DATA_W        32
`define EMB_NUM_STATIC    8
`define EMB_NUM_SDRAM     2

// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define EMB_SD_BA_HI      14
`define EMB_SD_BA_LO      13
`define EMB_SD_AP_BIT     10
`define EMB_BANK_SEL_HI   2
`define EMB_STRAP_BYTE    2'h1
`define EMB_STRAP_HALF    2'h2
`define EMB_STRAP_WORD    2'h3
`define EMB_STRAP_RSVD    2'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define EMB_RST_FILT_CYC  64
`define EMB_RST_CNT_W     7
`define EMB_STATIC_CYC    4'h2
`define EMB_SD_CAS_CYC    4'h2

`endif

// ### shared/emb_pkg.sv
// Types for the external memory bus interface
package emb_pkg;

   typedef enum logic [1:0] {
      EMB_W8  = 2'h0,
      EMB_W16 = 2'h1,
      EMB_W32 = 2'h2
   } emb_width_t;

   typedef enum logic [6:0] {
      EMB_IDLE  = 7'h01,
      EMB_STAT  = 7'h02,
      EMB_WAIT  = 7'h04,
      EMB_ACT   = 7'h08,
      EMB_CMD   = 7'h10,
      EMB_CAS   = 7'h20,
      EMB_HIZ   = 7'h40
   } emb_state_t;

endpackage

// ### rtl/emb_ctrl.sv
// External memory bus interface controller
`timescale 1ns/10ps
`include "emb_consts.svh"

module emb_ctrl (
   // Clock and reset
   input  wire logic                     ref_clk_i,
   input  wire logic                     rst_b_i,
   // Straps
   input  wire logic [1:0]               boot_bank_width_strap_i,
   input  wire logic                     big_endian_strap_i,
   // Internal access request
   input  wire logic                     req_valid_i,
   input  wire logic                     req_write_i,
   input  wire logic                     req_sdram_i,
   input  wire logic [2:0]               req_bank_i,
   input  wire logic [`EMB_ADDR_W-1:0]   req_addr_i,
   input  wire logic [1:0]               req_size_i,
   input  wire logic                     req_ap_i,
   input  wire logic [1:0]               req_width_i,
   input  wire logic [`EMB_DATA_W-1:0]   req_wdata_i,
   output logic                          req_ready_o,
   output logic                          rd_valid_o,
   output logic [`EMB_DATA_W-1:0]        rd_data_o,
   // Status
   output logic                          reset_done_o,
   output logic [1:0]                    boot_width_o,
   output logic                          width_error_o,
   // Memory pins
   output logic [`EMB_ADDR_W-1:0]        addr_o,
   output logic                          addr_oe_o,
   input  wire logic [`EMB_DATA_W-1:0]   external_data_bus_i,
   output logic [`EMB_DATA_W-1:0]        external_data_bus_o,
   output logic                          external_data_bus_oe_o,
   output logic [`EMB_NUM_STATIC-1:0]    static_bank_select_n_o,
   output logic [`EMB_NUM_SDRAM-1:0]     sdram_bank_select_n_o,
   output logic                          sdram_row_strobe_n_o,
   output logic                          sdram_column_strobe_n_o,
   output logic                          shared_write_strobe_n_o,
   output logic                          read_output_enable_n_o,
   output logic [3:0]                    byte_lane_write_n_o,
   output logic                          ctrl_oe_o,
   input  wire logic                     external_wait_n_i,
   // Bus handover
   input  wire logic                     ext_master_request_i,
   output logic                          ext_master_acknowledge_o
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Byte lane mask for size and offset, with byte order
   function automatic logic [3:0] lane_mask(input logic [1:0] sz,
                                            input logic [1:0] off,
                                            input logic       big);
      logic [3:0] m;
      logic [1:0] o;
      m = 4'h0;
      o = big ? ~off : off;
      unique case (sz)
         2'h0:    m = 4'h1 << o;
         2'h1:    m = big ? (4'h3 << {~off[1], 1'b0})
                          : (4'h3 << {off[1], 1'b0});
         default: m = 4'hf;
      endcase
      return m;
   endfunction

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic [4:0] nxt_sync1;
   logic [4:0] nxt_sync2;

   always_comb begin
      nxt_sync1 = {external_wait_n_i, ext_master_request_i,
                   big_endian_strap_i, boot_bank_width_strap_i};
      nxt_sync2 = sync1_ff;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_ff <= 5'h10;
         sync2_ff <= 5'h10;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
      end
   end

   logic wait_n_s;
   logic xreq_s;
   logic big_s;
   logic [1:0] bw_s;
   assign wait_n_s = sync2_ff[4];
   assign xreq_s   = sync2_ff[3];
   assign big_s    = sync2_ff[2];
   assign bw_s     = sync2_ff[1:0];

   // ------------------------------------------------------------
   // Reset filter and strap capture
   // ------------------------------------------------------------
   logic [`EMB_RST_CNT_W-1:0] rcnt_ff;
   logic [`EMB_RST_CNT_W-1:0] nxt_rcnt;
   logic [1:0]                bw_ff;
   logic [1:0]                nxt_bw;
   logic                      done;

   assign done = (rcnt_ff == `EMB_RST_CNT_W'(`EMB_RST_FILT_CYC));

   always_comb begin
      nxt_rcnt = rcnt_ff;
      nxt_bw   = bw_ff;
      if (!done) begin
         nxt_rcnt = rcnt_ff + `EMB_RST_CNT_W'(1);
         nxt_bw   = bw_s;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rcnt_ff <= '0;
         bw_ff   <= `EMB_STRAP_WORD;
      end else begin
         rcnt_ff <= nxt_rcnt;
         bw_ff   <= nxt_bw;
      end
   end

   // ------------------------------------------------------------
   // Access state machine
   // ------------------------------------------------------------
   emb_pkg::emb_state_t       st_ff, nxt_st;
   logic [3:0]                cnt_ff, nxt_cnt;
   logic [`EMB_ADDR_W-1:0]    a_ff, nxt_a;
   logic [`EMB_DATA_W-1:0]    wd_ff, nxt_wd;
   logic [`EMB_DATA_W-1:0]    rd_ff, nxt_rd;
   logic                      rv_ff, nxt_rv;
   logic                      wr_ff, nxt_wr;
   logic                      sd_ff, nxt_sd;
   logic                      ap_ff, nxt_ap;
   logic [2:0]                bk_ff, nxt_bk;
   logic [1:0]                wid_ff, nxt_wid;
   logic [3:0]                ln_ff, nxt_ln;
   logic                      werr_ff, nxt_werr;
   logic [1:0]                eff_w;
   logic                      bad_w;

   always_comb begin
      eff_w = req_width_i;
      if (!req_sdram_i && req_bank_i == 3'h0) begin
         unique case (bw_ff)
            `EMB_STRAP_BYTE: eff_w = emb_pkg::EMB_W8;
            `EMB_STRAP_HALF: eff_w = emb_pkg::EMB_W16;
            default:         eff_w = emb_pkg::EMB_W32;
         endcase
      end
      bad_w = (req_sdram_i && eff_w == emb_pkg::EMB_W8) ||
              (eff_w == 2'h3);
   end

   assign req_ready_o = done && (st_ff == emb_pkg::EMB_IDLE) && !xreq_s;

   always_comb begin
      nxt_st   = st_ff;
      nxt_cnt  = cnt_ff;
      nxt_a    = a_ff;
      nxt_wd   = wd_ff;
      nxt_rd   = rd_ff;
      nxt_rv   = 1'b0;
      nxt_wr   = wr_ff;
      nxt_sd   = sd_ff;
      nxt_ap   = ap_ff;
      nxt_bk   = bk_ff;
      nxt_wid  = wid_ff;
      nxt_ln   = ln_ff;
      nxt_werr = werr_ff;
      unique case (st_ff)
         emb_pkg::EMB_IDLE: begin
            if (done && xreq_s) begin
               nxt_st = emb_pkg::EMB_HIZ;
            end else if (req_valid_i && req_ready_o) begin
               nxt_werr = bad_w;
               if (!bad_w) begin
                  nxt_a   = req_addr_i;
                  nxt_wd  = req_wdata_i;
                  nxt_wr  = req_write_i;
                  nxt_sd  = req_sdram_i;
                  nxt_ap  = req_ap_i;
                  nxt_bk  = req_bank_i;
                  nxt_wid = eff_w;
                  nxt_ln  = lane_mask(req_size_i, req_addr_i[1:0], big_s);
                  nxt_cnt = req_sdram_i ? `EMB_SD_CAS_CYC
                                        : `EMB_STATIC_CYC;
                  nxt_st  = req_sdram_i ? emb_pkg::EMB_ACT
                                        : emb_pkg::EMB_STAT;
               end
            end
         end
         emb_pkg::EMB_STAT: begin
            nxt_cnt = cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) begin
               nxt_st = emb_pkg::EMB_WAIT;
            end
         end
         emb_pkg::EMB_WAIT: begin
            if (wait_n_s) begin
               nxt_rd = external_data_bus_i;
               nxt_rv = !wr_ff;
               nxt_st = emb_pkg::EMB_IDLE;
            end
         end
         emb_pkg::EMB_ACT: begin
            nxt_st = emb_pkg::EMB_CMD;
         end
         emb_pkg::EMB_CMD: begin
            nxt_st = wr_ff ? emb_pkg::EMB_IDLE : emb_pkg::EMB_CAS;
         end
         emb_pkg::EMB_CAS: begin
            nxt_cnt = cnt_ff - 4'h1;
            if (cnt_ff == 4'h1) begin
               nxt_rd = external_data_bus_i;
               nxt_rv = 1'b1;
               nxt_st = emb_pkg::EMB_IDLE;
            end
         end
         emb_pkg::EMB_HIZ: begin
            if (!xreq_s) begin
               nxt_st = emb_pkg::EMB_IDLE;
            end
         end
         default: nxt_st = emb_pkg::EMB_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff   <= emb_pkg::EMB_IDLE;
         cnt_ff  <= 4'h0;
         a_ff    <= '0;
         wd_ff   <= '0;
         rd_ff   <= '0;
         rv_ff   <= 1'b0;
         wr_ff   <= 1'b0;
         sd_ff   <= 1'b0;
         ap_ff   <= 1'b0;
         bk_ff   <= 3'h0;
         wid_ff  <= 2'h2;
         ln_ff   <= 4'h0;
         werr_ff <= 1'b0;
      end else begin
         st_ff   <= nxt_st;
         cnt_ff  <= nxt_cnt;
         a_ff    <= nxt_a;
         wd_ff   <= nxt_wd;
         rd_ff   <= nxt_rd;
         rv_ff   <= nxt_rv;
         wr_ff   <= nxt_wr;
         sd_ff   <= nxt_sd;
         ap_ff   <= nxt_ap;
         bk_ff   <= nxt_bk;
         wid_ff  <= nxt_wid;
         ln_ff   <= nxt_ln;
         werr_ff <= nxt_werr;
      end
   end

   // ------------------------------------------------------------
   // Pin decode
   // ------------------------------------------------------------
   logic stat_on;
   logic sd_cmd;
   logic wr_ph;

   assign stat_on = (st_ff == emb_pkg::EMB_STAT) ||
                    (st_ff == emb_pkg::EMB_WAIT);
   assign sd_cmd  = (st_ff == emb_pkg::EMB_CMD);
   assign wr_ph   = wr_ff && (stat_on || sd_cmd);

   always_comb begin
      addr_o = a_ff;
      if (sd_cmd) begin
         addr_o[`EMB_SD_AP_BIT] = ap_ff;
      end
      static_bank_select_n_o = '1;
      if (stat_on) begin
         static_bank_select_n_o[bk_ff] = 1'b0;
      end
      sdram_bank_select_n_o = '1;
      if (sd_ff && (st_ff == emb_pkg::EMB_ACT || sd_cmd)) begin
         sdram_bank_select_n_o[bk_ff[0]] = 1'b0;
      end
      sdram_row_strobe_n_o    = !(st_ff == emb_pkg::EMB_ACT);
      sdram_column_strobe_n_o = !sd_cmd;
      shared_write_strobe_n_o = !(wr_ph && (sd_ff ||
                                  wid_ff == emb_pkg::EMB_W16));
      read_output_enable_n_o  = !(!wr_ff && stat_on);
      if (sd_ff) begin
         byte_lane_write_n_o = sd_cmd ? ~ln_ff : 4'h0;
      end else begin
         byte_lane_write_n_o = wr_ph ? ~ln_ff : 4'hf;
      end
   end

   assign ctrl_oe_o              = (st_ff != emb_pkg::EMB_HIZ);
   assign addr_oe_o              = ctrl_oe_o;
   assign external_data_bus_oe_o = ctrl_oe_o && wr_ph;
   assign external_data_bus_o    = wd_ff;
   assign ext_master_acknowledge_o = (st_ff == emb_pkg::EMB_HIZ);
   assign rd_valid_o    = rv_ff;
   assign rd_data_o     = rd_ff;
   assign reset_done_o  = done;
   assign boot_width_o  = bw_ff;
   assign width_error_o = werr_ff;

endmodule

// ### tb/emb_checker.sv
// Pin-level assertions for the external memory bus controller
`timescale 1ns/10ps
module emb_checker (
   // Clock, reset and request
   input wire logic       ref_clk_i,
   input wire logic       rst_b_i,
   input wire logic       req_valid_i,
   input wire logic       req_ready_o,
   input wire logic       req_write_i,
   input wire logic       req_sdram_i,
   input wire logic [2:0] req_bank_i,
   input wire logic [1:0] req_width_i,
   input wire logic       reset_done_o,
   // Memory pins
   input wire logic [7:0] static_bank_select_n_o,
   input wire logic [1:0] sdram_bank_select_n_o,
   input wire logic       sdram_row_strobe_n_o,
   input wire logic       sdram_column_strobe_n_o,
   input wire logic       shared_write_strobe_n_o,
   input wire logic       read_output_enable_n_o,
   input wire logic       addr_oe_o,
   input wire logic       ctrl_oe_o,
   input wire logic       external_data_bus_oe_o,
   input wire logic       ext_master_request_i,
   input wire logic       ext_master_acknowledge_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   wire logic tk = req_valid_i && req_ready_o;
   wire logic st = tk && !req_sdram_i && req_width_i != 2'h3;

   chk_ready_filt: assert property (req_ready_o |-> reset_done_o)
      else $error("ready before reset filter done");
   chk_static_sel: assert property (st |=>
      !static_bank_select_n_o[$past(req_bank_i)])
      else $error("static select missing");
   chk_one_sel: assert property ($countones(~static_bank_select_n_o) <= 1
      && $countones(~sdram_bank_select_n_o) <= 1)
      else $error("two selects low");
   chk_row_col: assert property ($fell(sdram_column_strobe_n_o) |->
      $past(!sdram_row_strobe_n_o) && !(&sdram_bank_select_n_o))
      else $error("column strobe without row");
   chk_read_oe: assert property (st && !req_write_i |=>
      !read_output_enable_n_o)
      else $error("read enable missing");
   chk_no_we8: assert property (st && req_write_i && req_width_i == 2'h0
      && req_bank_i != 3'h0 |=> shared_write_strobe_n_o [*3])
      else $error("write strobe on byte write");
   chk_sd_we: assert property (tk && req_write_i && req_sdram_i &&
      req_width_i inside {2'h1, 2'h2} |-> ##[1:4]
      !shared_write_strobe_n_o)
      else $error("sdram write strobe missing");
   chk_ack_hiz: assert property (ext_master_acknowledge_o |-> !addr_oe_o
      && !ctrl_oe_o && !external_data_bus_oe_o && !req_ready_o)
      else $error("pins driven while granted");
   chk_ack_cause: assert property ($rose(ext_master_acknowledge_o) |->
      $past(ext_master_request_i))
      else $error("grant without request");
   chk_ack_drop: assert property ($fell(ext_master_request_i) |->
      ##[1:4] !ext_master_acknowledge_o)
      else $error("grant not withdrawn");

   cover property (tk && req_sdram_i);
   cover property (tk && req_write_i && !req_sdram_i);
   cover property ($rose(ext_master_acknowledge_o));
endmodule

bind emb_ctrl emb_checker u_chk (
   .ref_clk_i, .rst_b_i, .req_valid_i, .req_ready_o, .req_write_i,
   .req_sdram_i, .req_bank_i, .req_width_i, .reset_done_o,
   .static_bank_select_n_o, .sdram_bank_select_n_o, .sdram_row_strobe_n_o,
   .sdram_column_strobe_n_o, .shared_write_strobe_n_o,
   .read_output_enable_n_o, .addr_oe_o, .ctrl_oe_o,
   .external_data_bus_oe_o, .ext_master_request_i,
   .ext_master_acknowledge_o);

// ### tb/emb_mem_model.sv
// Behavioural static memory device for the controller bench
`timescale 1ns/10ps
module emb_mem_model (
   // Controller pins
   input  wire logic        ref_clk_i,
   input  wire logic [7:0]  sel_n_i,
   input  wire logic        oe_n_i,
   input  wire logic [23:0] addr_i,
   // Bench control
   input  wire logic [3:0]  slow_i,
   // Device outputs
   output logic [31:0]      data_o,
   output logic             wait_n_o
);
   logic [3:0]  cnt_ff = 4'h0;
   logic [7:0]  sel_ff = 8'hff;
   logic [31:0] last_ff = 32'h0;
   logic        hit;
   // Released bus toggles every cycle
   assign data_o = oe_n_i ? ~last_ff : {8'h5a, addr_i};
   // Slow device pulls wait as soon as it is selected
   assign hit = ((~sel_n_i & sel_ff) != 8'h0) && (slow_i != 4'h0);
   assign wait_n_o = (cnt_ff == 4'h0) && !hit;
   always @(posedge ref_clk_i) begin
      last_ff <= data_o;
      sel_ff  <= sel_n_i;
      if ((~sel_n_i & sel_ff) != 8'h0)
         cnt_ff <= slow_i;
      else if (cnt_ff != 4'h0)
         cnt_ff <= cnt_ff - 4'h1;
   end
endmodule

// ### tb/external_memory_bus_interface_tb.sv
// Self-checking bench for the external memory bus controller
`timescale 1ns/10ps
module external_memory_bus_interface_tb;
   logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, big = 1'b0, rv = 1'b0;
   logic        wr = 1'b0, sd = 1'b0, ap = 1'b0, mreq = 1'b0;
   logic [2:0]  bank = 3'h0;
   logic [1:0]  sz = 2'h0, wd = 2'h0;
   logic [23:0] adr = 24'h0, adr_o;
   logic [3:0]  slow = 4'h0, bln, ln_s;
   logic [31:0] rdat, dout, din, rd_s, dw_s;
   logic [7:0]  seln, sel_s;
   logic [1:0]  sdn, sd_s, bw, strap = 2'h1;
   logic        rdy, rdv, rdn, werr, aoe, doe, coe, ras, cas, wen, oen;
   logic        ack, waitn, oe_s, we_s, got;
   logic [23:0] cas_a;
   int          miscompares = 0, total_checks = 0, sel_c;

   emb_ctrl DUT (.ref_clk_i, .rst_b_i, .boot_bank_width_strap_i(strap),
      .big_endian_strap_i(big), .req_valid_i(rv), .req_write_i(wr),
      .req_sdram_i(sd), .req_bank_i(bank), .req_addr_i(adr),
      .req_size_i(sz), .req_ap_i(ap), .req_width_i(wd),
      .req_wdata_i(32'h1234abcd), .req_ready_o(rdy), .rd_valid_o(rdv),
      .rd_data_o(rdat), .reset_done_o(rdn), .boot_width_o(bw),
      .width_error_o(werr), .addr_o(adr_o), .addr_oe_o(aoe),
      .external_data_bus_i(din), .external_data_bus_o(dout),
      .external_data_bus_oe_o(doe), .static_bank_select_n_o(seln),
      .sdram_bank_select_n_o(sdn), .sdram_row_strobe_n_o(ras),
      .sdram_column_strobe_n_o(cas), .shared_write_strobe_n_o(wen),
      .read_output_enable_n_o(oen), .byte_lane_write_n_o(bln),
      .ctrl_oe_o(coe), .external_wait_n_i(waitn),
      .ext_master_request_i(mreq), .ext_master_acknowledge_o(ack));
   emb_mem_model u_mem (.ref_clk_i, .sel_n_i(seln), .oe_n_i(oen),
      .addr_i(adr_o), .slow_i(slow), .data_o(din), .wait_n_o(waitn));

   always #12.5 ref_clk_i = ~ref_clk_i;

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cmp(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic tmo;
      miscompares++;
      $display("wrong value wait exp done got timeout");
      end_sim;
   endtask

   // One access, monitoring the pins until the bus is idle or granted
   task automatic acc(input logic w, s, a, input logic [2:0] b,
                      input logic [1:0] z, d, input logic [23:0] ad,
                      input logic hold);
      int i;
      {sel_s, sd_s, oe_s, we_s, got, ln_s, cas_a, dw_s} = '0;
      sel_c = 0;
      {wr, sd, ap, bank, sz, wd, adr, rv} = {w, s, a, b, z, d, ad, 1'b1};
      for (i = 0; i < 200 && !rdy; i++) @(negedge ref_clk_i);
      if (!rdy) tmo;
      mreq = hold;
      @(negedge ref_clk_i);
      rv = 1'b0;
      for (i = 0; i < 40; i++) begin
         sel_s |= ~seln;
         sd_s |= ~sdn;
         oe_s |= ~oen;
         we_s |= ~wen;
         sel_c += int'(seln != 8'hff);
         if (seln != 8'hff && oen) ln_s |= ~bln;
         if (!cas) cas_a = adr_o;
         if (doe) dw_s = dout;
         if (rdv) {got, rd_s} = {1'b1, rdat};
         if (rdy || ack) break;
         @(negedge ref_clk_i);
      end
      if (i == 40) tmo;
   endtask

   task automatic t_reset;
      int n;
      n = 0;
      repeat (20) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      while (n < 200 && rdn !== 1'b1) begin
         @(negedge ref_clk_i);
         n++;
      end
      cmp("filter cycles", 32'd64, 32'(n));
      cmp("boot width", 32'(strap), 32'(bw));
      $display("reset test done");
   endtask

   task automatic t_banks;
      for (int b = 0; b < 8; b++) begin
         acc(0, 0, 0, 3'(b), 2'h2, 2'h2, 24'hfedcb0 + 24'(b * 4), 0);
         cmp("select", 32'h1 << b, 32'(sel_s));
         cmp("read enable", 32'h1, 32'(oe_s));
         if (b != 0) cmp("read data", {8'h5a, adr}, rd_s);
      end
      $display("bank test done");
   endtask

   task automatic t_writes;
      acc(1, 0, 0, 3'h2, 2'h1, 2'h1, 24'h10, 0);
      cmp("strobe 16", 32'h1, 32'(we_s));
      cmp("write data", 32'h1234abcd, dw_s);
      acc(1, 0, 0, 3'h3, 2'h0, 2'h0, 24'h11, 0);
      cmp("strobe 8", 32'h0, 32'(we_s));
      acc(1, 0, 0, 3'h5, 2'h0, 2'h2, 24'h21, 0);
      cmp("lanes little", 32'h2, 32'(ln_s));
      big = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      acc(1, 0, 0, 3'h5, 2'h0, 2'h2, 24'h21, 0);
      cmp("lanes big", 32'h4, 32'(ln_s));
      big = 1'b0;
      $display("write test done");
   endtask

   task automatic t_sdram;
      acc(1, 1, 0, 3'h0, 2'h0, 2'h0, 24'h2000, 0);
      cmp("sd byte error", 32'h1, 32'(werr));
      cmp("sd byte select", 32'h0, 32'(sd_s));
      acc(0, 0, 0, 3'h6, 2'h2, 2'h3, 24'h40, 0);
      cmp("width code 3", 32'h1, 32'(werr));
      cmp("code 3 select", 32'h0, 32'(sel_s));
      acc(0, 1, 1, 3'h1, 2'h2, 2'h2, 24'h6000, 0);
      cmp("sd select 1", 32'h2, 32'(sd_s));
      cmp("sd bank bits", 32'h3, 32'(cas_a[14:13]));
      cmp("precharge", 32'h1, 32'(cas_a[10]));
      cmp("sd read", 32'h1, 32'(got));
      acc(1, 1, 0, 3'h0, 2'h1, 2'h1, 24'h2000, 0);
      cmp("sd strobe", 32'h1, 32'(we_s));
      cmp("sd select 0", 32'h1, 32'(sd_s));
      cmp("no precharge", 32'h0, 32'(cas_a[10]));
      cmp("sd error clear", 32'h0, 32'(werr));
      $display("sdram test done");
   endtask

   task automatic t_wait;
      int f;
      acc(0, 0, 0, 3'h4, 2'h2, 2'h2, 24'h88, 0);
      f = sel_c;
      slow = 4'h6;
      acc(0, 0, 0, 3'h4, 2'h2, 2'h2, 24'h88, 0);
      cmp("stretch", 32'h1, 32'(sel_c >= f + 4));
      cmp("slow data", 32'h5a000088, rd_s);
      slow = 4'h0;
      $display("wait test done");
   endtask

   task automatic t_hand;
      int i;
      acc(0, 0, 0, 3'h7, 2'h2, 2'h2, 24'h77, 1);
      cmp("finish first", 32'h1, 32'(got));
      for (i = 0; i < 10 && ack !== 1'b1; i++) @(negedge ref_clk_i);
      cmp("grant", 32'h1, 32'(ack));
      cmp("pins released", 32'h0, 32'({aoe, coe, doe}));
      // master drops request after its refresh
      mreq = 1'b0;
      for (i = 0; i < 10 && ack !== 1'b0; i++) @(negedge ref_clk_i);
      cmp("grant low", 32'h0, 32'(ack));
      acc(0, 0, 0, 3'h7, 2'h2, 2'h2, 24'h78, 0);
      cmp("resumed", 32'h1, 32'(got));
      $display("handover test done");
   endtask

   task automatic t_strap;
      strap = 2'h2;
      rst_b_i = 1'b0;
      t_reset;
      acc(1, 0, 0, 3'h0, 2'h1, 2'h0, 24'h30, 0);
      cmp("bank0 half strobe", 32'h1, 32'(we_s));
      $display("strap test done");
   endtask

   initial begin
      t_reset;
      t_banks;
      t_writes;
      t_sdram;
      t_wait;
      t_hand;
      t_strap;
      end_sim;
   end
endmodule
